// >>> src/iffc_pkg.sv
// Package: constants, types and helpers of the integrity flag control block
// Behaviour
// - Result-invert flag complements final guard CRC
// - Seed-invert flag picks CRC seed 0 or 0xffff
// - Source ref tag type: 0 increments, 1 fixed
// - Ref check disable skips reference tag check
// - Guard check disable skips guard comparison
// - Source app tag type: 0 fixed, 1 increments
// - App+ref all ones skips tag and guard checks
// - App all ones skips app, guard, ref checks
// - All three fields ones bypasses every check
// - All-ones error enable reports all-ones error
// - All-ones error enable ignored without detection
// - Integrity computed separately per source block
// - Mismatch stops, records status and bytes done
package iffc_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_XFER = 8'h08;
   localparam logic [7:0] ADDR_REF_SEED = 8'h0c;
   localparam logic [7:0] ADDR_APP_SEED = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_BYTES_DONE = 8'h18;
   localparam logic [7:0] ADDR_REF_CUR = 8'h1c;
   localparam logic [7:0] ADDR_APP_CUR = 8'h20;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h24;
   localparam logic [7:0] ADDR_INT_MASK = 8'h28;
   // Interrupt status bit positions
   localparam int INT_DONE = 0;
   localparam int INT_ERR = 1;
   // Integrity status codes
   localparam logic [7:0] STAT_GUARD = 8'h01;
   localparam logic [7:0] STAT_APP = 8'h02;
   localparam logic [7:0] STAT_REF = 8'h04;
   localparam logic [7:0] STAT_ALL_ONES = 8'h08;
   localparam logic [15:0] CRC_POLY = 16'h8bb7;
   localparam logic [15:0] CRC_SEED_ONES = 16'hffff;
   localparam logic [15:0] CRC_SEED_ZERO = 16'h0000;
   localparam logic [12:0] DIF_BYTES = 13'h008;
   localparam logic [2:0] DIF_LAST = 3'h7;
   typedef struct packed {
      logic [3:0] rsvd;
      logic invert_result;
      logic invert_seed;
      logic [1:0] block_size;
   } iffc_flags_t;
   typedef struct packed {
      logic ref_fixed;
      logic ref_check_dis;
      logic guard_check_dis;
      logic app_incr;
      logic app_ref_detect;
      logic app_detect;
      logic all_detect;
      logic all_error_en;
   } iffc_src_flags_t;
   typedef struct packed {
      logic [15:0] guard;
      logic [15:0] app;
      logic [31:0] ref_tag;
   } iffc_dif_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_TAGS = 2'b10,
      ST_CHECK = 2'b11
   } iffc_state_t;
   function automatic logic [12:0] iffc_block_len(input logic [1:0] code);
      case (code)
         2'b00: iffc_block_len = 13'd512;
         2'b01: iffc_block_len = 13'd520;
         2'b10: iffc_block_len = 13'd4096;
         default: iffc_block_len = 13'd4104;
      endcase
   endfunction
   function automatic logic [15:0] iffc_crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
      end
      iffc_crc_byte = r;
   endfunction
endpackage

// >>> src/iffc_top.sv
// Integrity flag control: AHB-Lite registers and source block checker
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
module iffc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic src_valid,
   output logic src_ready,
   input wire logic [7:0] src_byte,
   output logic busy,
   output logic irq
);
   import iffc_pkg::*;

   iffc_state_t state;
   iffc_flags_t flags;
   iffc_src_flags_t src_flags;
   iffc_dif_t dif;
   logic [31:0] xfer_size;
   logic [31:0] ref_seed;
   logic [15:0] app_seed;
   logic [15:0] app_mask;
   logic [31:0] ref_cur;
   logic [15:0] app_cur;
   logic [31:0] bytes_done;
   logic [7:0] status_code;
   logic [1:0] int_status;
   logic [1:0] int_mask;
   logic [12:0] byte_cnt;
   logic [2:0] dif_cnt;
   logic [15:0] crc;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic start;
   logic ev_done;
   logic ev_err;
   logic [15:0] guard_calc;
   logic [15:0] crc_seed;
   logic [12:0] blk_len;
   logic app_ones;
   logic ref_ones;
   logic guard_ones;
   logic skip_all;
   logic all_ones_err;
   logic [7:0] chk_code;
   logic [31:0] next_bytes;
   logic take;
   logic [1:0] int_clr;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign busy = (state != ST_IDLE);
   assign irq = |(int_status & int_mask);
   assign src_ready = (state == ST_DATA) || (state == ST_TAGS);
   assign take = src_valid && src_ready;

   // Bus write address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // Read data registered in the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            ADDR_FLAGS: hrdata <= {16'h0000, src_flags, flags};
            ADDR_XFER: hrdata <= xfer_size;
            ADDR_REF_SEED: hrdata <= ref_seed;
            ADDR_APP_SEED: hrdata <= {app_mask, app_seed};
            ADDR_STATUS: hrdata <= {16'h0000, status_code, 7'h00, busy};
            ADDR_BYTES_DONE: hrdata <= bytes_done;
            ADDR_REF_CUR: hrdata <= ref_cur;
            ADDR_APP_CUR: hrdata <= {16'h0000, app_cur};
            ADDR_INT_STATUS: hrdata <= {30'h0000_0000, int_status};
            ADDR_INT_MASK: hrdata <= {30'h0000_0000, int_mask};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   assign start = wr_pend && (wr_addr == ADDR_CTRL) && hwdata[0] && (state == ST_IDLE);
   assign int_clr = (wr_pend && (wr_addr == ADDR_INT_STATUS)) ? hwdata[1:0] : 2'b00;

   // Configuration registers; all but the interrupt mask held while an operation runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= '0;
         src_flags <= '0;
         xfer_size <= 32'h0000_0000;
         ref_seed <= 32'h0000_0000;
         app_seed <= 16'h0000;
         app_mask <= 16'h0000;
         int_mask <= 2'b00;
      end else if (wr_pend) begin
         if (wr_addr == ADDR_INT_MASK) begin
            int_mask <= hwdata[1:0];
         end
         if (state == ST_IDLE) begin
            case (wr_addr)
               ADDR_FLAGS: begin
                  flags <= hwdata[7:0];
                  src_flags <= hwdata[15:8];
               end
               ADDR_XFER: xfer_size <= hwdata;
               ADDR_REF_SEED: ref_seed <= hwdata;
               ADDR_APP_SEED: begin
                  app_seed <= hwdata[15:0];
                  app_mask <= hwdata[31:16];
               end
               default: ;
            endcase
         end
      end
   end

   // Sticky interrupt status, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_status <= 2'b00;
      end else begin
         int_status[INT_DONE] <= ev_done || (int_status[INT_DONE] && !int_clr[INT_DONE]);
         int_status[INT_ERR] <= ev_err || (int_status[INT_ERR] && !int_clr[INT_ERR]);
      end
   end

   assign blk_len = iffc_block_len(flags.block_size);
   assign crc_seed = flags.invert_seed ? CRC_SEED_ONES : CRC_SEED_ZERO;
   assign guard_calc = flags.invert_result ? ~crc : crc;

   assign app_ones = (dif.app == 16'hffff);
   assign ref_ones = (dif.ref_tag == 32'hffff_ffff);
   assign guard_ones = (dif.guard == 16'hffff);

   // Tag value detection that waives checks on a block
   always_comb begin
      skip_all = 1'b0;
      if (src_flags.app_ref_detect && app_ones && ref_ones) begin
         skip_all = 1'b1;
      end
      if (src_flags.app_detect && app_ones) begin
         skip_all = 1'b1;
      end
      if (src_flags.all_detect && app_ones && ref_ones && guard_ones) begin
         skip_all = 1'b1;
      end
   end

   // Error enable only counts when all-ones detection is on
   assign all_ones_err = src_flags.all_detect && src_flags.all_error_en
      && app_ones && ref_ones && guard_ones;

   // Per-block comparison of the captured integrity field
   always_comb begin
      chk_code = 8'h00;
      if (all_ones_err) begin
         chk_code = STAT_ALL_ONES;
      end else if (!skip_all) begin
         if (!src_flags.guard_check_dis && (dif.guard != guard_calc)) begin
            chk_code = chk_code | STAT_GUARD;
         end
         if ((app_mask != 16'hffff) && ((dif.app & ~app_mask) != (app_cur & ~app_mask))) begin
            chk_code = chk_code | STAT_APP;
         end
         if (!src_flags.ref_check_dis && (dif.ref_tag != ref_cur)) begin
            chk_code = chk_code | STAT_REF;
         end
      end
   end

   assign next_bytes = bytes_done + {19'h00000, blk_len} + {19'h00000, DIF_BYTES};

   // Operation sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  state <= (xfer_size == 32'h0000_0000) ? ST_CHECK : ST_DATA;
               end
            end
            ST_DATA: begin
               if (take && (byte_cnt == blk_len - 13'd1)) begin
                  state <= ST_TAGS;
               end
            end
            ST_TAGS: begin
               if (take && (dif_cnt == DIF_LAST)) begin
                  state <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (xfer_size == 32'h0000_0000) begin
                  state <= ST_IDLE;
               end else if (chk_code != 8'h00) begin
                  state <= ST_IDLE;
               end else if (next_bytes >= xfer_size) begin
                  state <= ST_IDLE;
               end else begin
                  state <= ST_DATA;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign ev_done = (state == ST_CHECK) && (chk_code == 8'h00 || xfer_size == 32'h0000_0000)
      && ((xfer_size == 32'h0000_0000) || (next_bytes >= xfer_size));
   assign ev_err = (state == ST_CHECK) && (xfer_size != 32'h0000_0000) && (chk_code != 8'h00);

   // Byte counters and guard CRC, restarted for every block
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byte_cnt <= 13'h0000;
         dif_cnt <= 3'h0;
         crc <= 16'h0000;
         dif <= '0;
      end else if (start || (state == ST_CHECK)) begin
         byte_cnt <= 13'h0000;
         dif_cnt <= 3'h0;
         crc <= crc_seed;
      end else if (take && (state == ST_DATA)) begin
         byte_cnt <= byte_cnt + 13'd1;
         crc <= iffc_crc_byte(crc, src_byte);
      end else if (take && (state == ST_TAGS)) begin
         dif_cnt <= dif_cnt + 3'h1;
         dif <= {dif[55:0], src_byte};
      end
   end

   // Expected tags, progress and completion status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_cur <= 32'h0000_0000;
         app_cur <= 16'h0000;
         bytes_done <= 32'h0000_0000;
         status_code <= 8'h00;
      end else if (start) begin
         ref_cur <= ref_seed;
         app_cur <= app_seed;
         bytes_done <= 32'h0000_0000;
         status_code <= 8'h00;
      end else if ((state == ST_CHECK) && (xfer_size != 32'h0000_0000)) begin
         if (chk_code != 8'h00) begin
            status_code <= chk_code;
         end else begin
            bytes_done <= next_bytes;
            if (!src_flags.ref_fixed) begin
               ref_cur <= ref_cur + 32'd1;
            end
            if (src_flags.app_incr) begin
               app_cur <= app_cur + 16'd1;
            end
         end
      end
   end
endmodule

// >>> dv/iffc_src_model.sv
// Source byte stream model with optional stalls
`timescale 1ns/1ns
module iffc_src_model (
   input wire logic hclk,
   input wire logic slow,
   input wire logic src_ready,
   output logic src_valid,
   output logic [7:0] src_byte
);
   logic [7:0] q[$];
   logic [7:0] lf = 8'h5a;
   initial src_valid = 1'b0;
   initial src_byte = 8'h00;
   // Holds a byte until taken; idle data toggles so a stale value never matches
   always @(posedge hclk) begin
      if (src_valid && src_ready) void'(q.pop_front());
      if (!src_valid || src_ready) begin
         lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
         if (q.size() > 0 && !(slow && lf[0])) begin
            src_valid <= 1'b1;
            src_byte <= q[0];
         end else begin
            src_valid <= 1'b0;
            src_byte <= ~src_byte;
         end
      end
   end
endmodule

// >>> dv/iffc_chk.sv
// Checker: port-level assertions of the integrity flag control block
`timescale 1ns/1ns
module iffc_chk
   import iffc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic src_valid,
   input wire logic src_ready,
   input wire logic busy,
   input wire logic irq
);
   logic a_v;
   logic a_w;
   logic [7:0] a_a;
   logic [1:0] size_q;
   logic [12:0] cnt;
   logic [12:0] last;
   assign last = (size_q[1] ? 13'd4096 : 13'd512) + (size_q[0] ? 13'd8 : 13'd0) + 13'd7;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_v <= 1'b0;
         a_w <= 1'b0;
         a_a <= 8'h00;
      end else begin
         a_v <= hsel && htrans[1] && hready;
         a_w <= hwrite;
         a_a <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) size_q <= 2'b00;
      else if (a_v && a_w && a_a == ADDR_FLAGS && !busy) size_q <= hwdata[1:0];
   end
   // Byte position inside the current block including its integrity bytes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cnt <= 13'd0;
      else if (!busy) cnt <= 13'd0;
      else if (src_valid && src_ready) cnt <= (cnt == last) ? 13'd0 : cnt + 13'd1;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_BLOCK_END: assert property (src_valid && src_ready && cnt == last |=> !src_ready)
      else $error("ready after block end");
   AST_BLOCK_FIRST: assert property ($rose(src_ready) |-> cnt == 13'd0)
      else $error("block starts mid count");
   AST_MID_BLOCK: assert property (busy && cnt != 13'd0 |-> src_ready)
      else $error("ready dropped in block");
   AST_CHECK_GAP: assert property (busy && !src_ready |=> src_ready || !busy)
      else $error("check gap too long");
   AST_IDLE_QUIET: assert property (!busy |-> !src_ready)
      else $error("ready while idle");
   AST_START: assert property (a_v && a_w && a_a == ADDR_CTRL && hwdata[0] && !busy |=> busy)
      else $error("start ignored");
   AST_BUSY_BIT: assert property (hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ADDR_STATUS
      |=> hrdata[0] == $past(busy))
      else $error("status busy bit wrong");
   AST_MASK_OFF: assert property (a_v && a_w && a_a == ADDR_INT_MASK && hwdata == 32'h0 |=> !irq)
      else $error("irq while masked");
endmodule
bind iffc_top iffc_chk iffc_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .src_valid(src_valid), .src_ready(src_ready), .busy(busy), .irq(irq));

// >>> dv/iffc_tb.sv
// Testbench: descriptor flag scenarios over AHB-Lite and the source stream
`timescale 1ns/1ns
module testbench;
   import iffc_pkg::*;
   logic hclk = 0;
   logic hresetn = 0;
   logic hsel = 0;
   logic [31:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic hwrite = 0;
   logic [31:0] hwdata = 0;
   logic hreadyout, hresp, src_valid, src_ready, busy, irq;
   logic [31:0] hrdata;
   logic [7:0] src_byte;
   logic slow = 0;
   logic [15:0] lf = 16'h6;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   // Rows: flags, source flags, blocks, {ones mask, flip mask} of the last block
   logic [31:0] tbl [15] = '{32'h00000200, 32'hfd900200, 32'h02100100, 32'h07000101,
      32'h00200101, 32'h00000204, 32'h00400104, 32'h00000102, 32'h00080131, 32'h00000131,
      32'h00040115, 32'h00020138, 32'h00030138, 32'h00010138, 32'h010a0138};
   always #5 hclk = ~hclk;
   iffc_top iffc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_valid(src_valid),
      .src_ready(src_ready), .src_byte(src_byte), .busy(busy), .irq(irq));
   iffc_src_model iffc_src_model_inst (.hclk(hclk), .slow(slow), .src_ready(src_ready),
      .src_valid(src_valid), .src_byte(src_byte));
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
      return c;
   endfunction
   function automatic logic [7:0] ecode(input logic [7:0] sf, input logic [5:0] k);
      logic [2:0] bd;
      bd = k[5:3] | k[2:0];
      if (sf[1] && &k[5:3]) return sf[0] ? 8'h08 : 8'h00;
      if ((sf[3] && &k[5:4]) || (sf[2] && k[4])) return 8'h00;
      return {5'h0, bd[2] && !sf[6], bd[1], bd[0] && !sf[5]};
   endfunction
   task automatic end_of_test();
      $display("mismatches %0d compares %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic op(input logic [7:0] fl, input logic [7:0] sf, input int nb, input logic [5:0] k);
      logic [15:0] c, g, as, af;
      logic [31:0] rs, rf, r;
      logic [63:0] t;
      logic [7:0] e;
      int len;
      len = 512 * (fl[1] ? 8 : 1) + (fl[0] ? 8 : 0);
      lf = nx(lf);
      rs = {16'h0, lf};
      lf = nx(lf);
      as = {1'b0, lf[14:0]};
      e = ecode(sf, k);
      for (int b = 0; b < nb; b++) begin
         c = fl[2] ? 16'hffff : 16'h0000;
         for (int i = 0; i < len; i++) begin
            lf = nx(lf);
            c = crc8(c, lf[7:0]);
            iffc_src_model_inst.q.push_back(lf[7:0]);
         end
         g = fl[3] ? ~c : c;
         af = as + (sf[4] ? 16'(b) : 16'h0);
         rf = rs + (sf[7] ? 32'h0 : 32'(b));
         if (b == nb - 1) begin
            g = k[3] ? 16'hffff : (k[0] ? ~g : g);
            af = k[4] ? 16'hffff : (k[1] ? ~af : af);
            rf = k[5] ? 32'hffffffff : (k[2] ? ~rf : rf);
         end
         t = {g, af, rf};
         for (int i = 7; i >= 0; i--) iffc_src_model_inst.q.push_back(t[i * 8 +: 8]);
      end
      wr(ADDR_FLAGS, {16'h0, sf, fl});
      wr(ADDR_XFER, 32'(nb * (len + 8)));
      wr(ADDR_REF_SEED, rs);
      wr(ADDR_APP_SEED, {16'h0, as});
      wr(ADDR_CTRL, 32'h1);
      @(posedge hclk);
      while (busy === 1'b1) @(posedge hclk);
      rd(ADDR_FLAGS, {16'h0, sf, fl});
      rd(ADDR_STATUS, {16'h0, e, 8'h0});
      rd(ADDR_BYTES_DONE, 32'((e == 0 ? nb : nb - 1) * (len + 8)));
      if (k == 0) rd(ADDR_REF_CUR, rs + (sf[7] ? 32'h0 : 32'(nb)));
      if (k == 0) rd(ADDR_APP_CUR, {16'h0, as + (sf[4] ? 16'(nb) : 16'h0)});
      bus(1'b0, ADDR_INT_STATUS, 32'h0, r);
      chk({30'h0, r[1:0]}, {30'h0, e != 0, e == 0});
      chk({31'h0, irq}, 32'h1);
      wr(ADDR_INT_MASK, 32'h0);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_INT_MASK, 32'h3);
      wr(ADDR_INT_STATUS, 32'h3);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(8'h3c, 32'h0);
      wr(ADDR_INT_MASK, 32'h3);
      foreach (tbl[i]) begin
         slow <= i[0];
         op(tbl[i][31:24], tbl[i][23:16], int'(tbl[i][15:8]), tbl[i][5:0]);
      end
      lf = nx(lf);
      op(8'h00, {lf[7:4], 4'h0}, 2, 6'h00);
      // Empty transfer finishes after one check cycle with done set
      wr(ADDR_XFER, 32'h0);
      wr(ADDR_CTRL, 32'h1);
      @(posedge hclk);
      while (busy === 1'b1) @(posedge hclk);
      rd(ADDR_BYTES_DONE, 32'h0);
      rd(ADDR_INT_STATUS, 32'h1);
      end_of_test();
   end
endmodule
